// ==== include/hae_pkg.sv ====
// Constants, carriers and types for the Hall and analog encoder decoder
package hae_pkg;

  // ----------------------------------------
  // Register indexes
  // ----------------------------------------
  localparam logic [7:0] ADDR_HALL_MODE = 8'h33;
  localparam logic [7:0] ADDR_HALL_OFFSETS = 8'h37;
  localparam logic [7:0] ADDR_HALL_MAX_STEP = 8'h38;
  localparam logic [7:0] ADDR_HALL_ELEC = 8'h39;
  localparam logic [7:0] ADDR_HALL_MECH = 8'h3A;
  localparam logic [7:0] ADDR_AENC_CONFIG = 8'h3B;
  localparam logic [7:0] ADDR_AENC_THRESHOLD = 8'h3C;
  localparam logic [7:0] ADDR_AENC_RAW = 8'h3D;
  localparam logic [7:0] ADDR_AENC_OFFSET = 8'h3E;
  localparam logic [7:0] ADDR_AENC_COMP = 8'h3F;
  localparam logic [7:0] ADDR_AENC_PPR = 8'h40;
  localparam logic [7:0] ADDR_AENC_COUNT = 8'h41;
  localparam logic [7:0] ADDR_AENC_CAPTURE = 8'h42;
  localparam logic [7:0] ADDR_AENC_ANGLE_OFFSETS = 8'h45;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int HALL_MODE_INTERP_BIT = 8;
  localparam int AENC_THREE_PHASE_BIT = 0;
  localparam int AENC_RELOAD_BIT = 8;
  localparam int AENC_DIR_NEG_BIT = 12;
  localparam logic [15:0] MAX_STEP_RESET = 16'h2AAA;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [15:0] SIXTY_DEG = 16'h2AAB;
  localparam logic [15:0] HALF_TURN = 16'h8000;
  localparam logic [16:0] INV_SQRT3 = 17'h049E7;
  localparam int INV_SQRT3_SHIFT = 15;
  localparam logic [3:0] CORDIC_LAST = 4'hD;
  localparam logic [15:0] INTERVAL_MAX = 16'hFFFF;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hae_bus_req_t;

  typedef struct packed {
    logic signed [15:0] ph0;
    logic signed [15:0] ph1;
    logic signed [15:0] ph2;
    logic [15:0] index_level;
  } hae_aenc_in_t;

  typedef enum logic [1:0] {
    CORDIC_LOAD = 2'b00,
    CORDIC_ITER = 2'b01,
    CORDIC_DONE = 2'b11
  } hae_cordic_state_t;

  // Arctangent of 2^-i, full turn is 2^16
  function automatic logic [15:0] atan_lut(input logic [3:0] i);
    case (i)
      4'h0: atan_lut = 16'h2000;
      4'h1: atan_lut = 16'h12E4;
      4'h2: atan_lut = 16'h09FB;
      4'h3: atan_lut = 16'h0511;
      4'h4: atan_lut = 16'h028B;
      4'h5: atan_lut = 16'h0146;
      4'h6: atan_lut = 16'h00A3;
      4'h7: atan_lut = 16'h0051;
      4'h8: atan_lut = 16'h0029;
      4'h9: atan_lut = 16'h0014;
      4'hA: atan_lut = 16'h000A;
      4'hB: atan_lut = 16'h0005;
      4'hC: atan_lut = 16'h0003;
      default: atan_lut = 16'h0001;
    endcase
  endfunction

endpackage

// ==== core/hae_decoder.sv ====
// Hall and analog encoder angle decoder with register port
`timescale 1ns/10ps
`default_nettype none

module hae_decoder (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire hae_pkg::hae_bus_req_t bus_req,
  output var logic [31:0] rd_data,
  input wire logic [2:0] hall_in,
  input wire hae_pkg::hae_aenc_in_t aenc_in,
  output var logic [15:0] hall_phi_e_sel,
  output var logic [15:0] hall_phi_m_out,
  output var logic [15:0] aenc_phi_a_out,
  output var logic aenc_index_pulse
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [3:0] msb_index(input logic [15:0] v);
    msb_index = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        msb_index = 4'(i);
      end
    end
  endfunction

  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    case (h)
      3'h1: hall_sector = 3'h0;
      3'h3: hall_sector = 3'h1;
      3'h2: hall_sector = 3'h2;
      3'h6: hall_sector = 3'h3;
      3'h4: hall_sector = 3'h4;
      3'h5: hall_sector = 3'h5;
      default: hall_sector = 3'h7;
    endcase
  endfunction

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [31:0] hall_mode_reg, hall_mode_next;
  logic [31:0] hall_angle_offsets_reg, hall_angle_offsets_next;
  logic [15:0] hall_interp_max_step_reg, hall_interp_max_step_next;
  logic [31:0] analog_enc_config_reg, analog_enc_config_next;
  logic [15:0] analog_index_threshold_reg, analog_index_threshold_next;
  logic [15:0] analog_angle_offset_reg, analog_angle_offset_next;
  logic [15:0] analog_periods_per_rev_reg, analog_periods_per_rev_next;
  logic [31:0] analog_angle_offsets_reg, analog_angle_offsets_next;
  logic [31:0] rd_data_next;

  // ----------------------------------------
  // Hall state
  // ----------------------------------------
  logic [2:0] sector_reg, sector_next;
  logic [15:0] interval_reg, interval_next;
  logic [15:0] step_reg, step_next;
  logic [15:0] acc_reg, acc_next;
  logic fwd_reg, fwd_next;
  logic [15:0] hall_raw_reg, hall_raw_next;
  logic [15:0] hall_interp_reg, hall_interp_next;
  logic [15:0] hall_mech_reg, hall_mech_next;
  logic [15:0] hall_sel_next;

  // ----------------------------------------
  // Analog state
  // ----------------------------------------
  hae_pkg::hae_cordic_state_t cst_reg, cst_next;
  logic [3:0] iter_reg, iter_next;
  logic signed [17:0] x_reg, x_next, y_reg, y_next;
  logic [15:0] z_reg, z_next;
  logic [15:0] analog_raw_angle_reg, analog_raw_angle_next;
  logic [15:0] analog_comp_angle_reg, analog_comp_angle_next;
  logic [15:0] comp_prev_reg, comp_prev_next;
  logic [31:0] analog_period_count_reg, analog_period_count_next;
  logic [31:0] analog_index_capture_reg, analog_index_capture_next;
  logic index_level_reg, index_level_next;
  logic index_pulse_next;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_comb begin
    hall_mode_next = hall_mode_reg;
    hall_angle_offsets_next = hall_angle_offsets_reg;
    hall_interp_max_step_next = hall_interp_max_step_reg;
    analog_enc_config_next = analog_enc_config_reg;
    analog_index_threshold_next = analog_index_threshold_reg;
    analog_angle_offset_next = analog_angle_offset_reg;
    analog_periods_per_rev_next = analog_periods_per_rev_reg;
    analog_angle_offsets_next = analog_angle_offsets_reg;
    rd_data_next = hae_pkg::REG_RESET;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (bus_req.wr) begin
      case (bus_req.addr)
        hae_pkg::ADDR_HALL_MODE: hall_mode_next = bus_req.wdata;
        hae_pkg::ADDR_HALL_OFFSETS: hall_angle_offsets_next = bus_req.wdata;
        hae_pkg::ADDR_HALL_MAX_STEP: hall_interp_max_step_next = bus_req.wdata[15:0];
        hae_pkg::ADDR_AENC_CONFIG: analog_enc_config_next = bus_req.wdata;
        hae_pkg::ADDR_AENC_THRESHOLD: analog_index_threshold_next = bus_req.wdata[15:0];
        hae_pkg::ADDR_AENC_OFFSET: analog_angle_offset_next = bus_req.wdata[15:0];
        hae_pkg::ADDR_AENC_PPR: analog_periods_per_rev_next = bus_req.wdata[15:0];
        hae_pkg::ADDR_AENC_ANGLE_OFFSETS: analog_angle_offsets_next = bus_req.wdata;
        default: ;
      endcase
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    if (bus_req.rd) begin
      case (bus_req.addr)
        hae_pkg::ADDR_HALL_MODE: rd_data_next = hall_mode_reg;
        hae_pkg::ADDR_HALL_OFFSETS: rd_data_next = hall_angle_offsets_reg;
        hae_pkg::ADDR_HALL_MAX_STEP: rd_data_next = {16'h0000, hall_interp_max_step_reg};
        hae_pkg::ADDR_HALL_ELEC: rd_data_next = {hall_interp_reg, hall_raw_reg};
        hae_pkg::ADDR_HALL_MECH: rd_data_next = {16'h0000, hall_mech_reg};
        hae_pkg::ADDR_AENC_CONFIG: rd_data_next = analog_enc_config_reg;
        hae_pkg::ADDR_AENC_THRESHOLD: rd_data_next = {16'h0000, analog_index_threshold_reg};
        hae_pkg::ADDR_AENC_RAW: rd_data_next = {16'h0000, analog_raw_angle_reg};
        hae_pkg::ADDR_AENC_OFFSET: rd_data_next = {16'h0000, analog_angle_offset_reg};
        hae_pkg::ADDR_AENC_COMP: rd_data_next = {16'h0000, analog_comp_angle_reg};
        hae_pkg::ADDR_AENC_PPR: rd_data_next = {16'h0000, analog_periods_per_rev_reg};
        hae_pkg::ADDR_AENC_COUNT: rd_data_next = analog_period_count_reg;
        hae_pkg::ADDR_AENC_CAPTURE: rd_data_next = analog_index_capture_reg;
        hae_pkg::ADDR_AENC_ANGLE_OFFSETS: rd_data_next = analog_angle_offsets_reg;
        default: rd_data_next = hae_pkg::REG_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hall_mode_reg <= hae_pkg::REG_RESET;
      hall_angle_offsets_reg <= hae_pkg::REG_RESET;
      hall_interp_max_step_reg <= hae_pkg::MAX_STEP_RESET;
      analog_enc_config_reg <= hae_pkg::REG_RESET;
      analog_index_threshold_reg <= 16'h0000;
      analog_angle_offset_reg <= 16'h0000;
      analog_periods_per_rev_reg <= 16'h0000;
      analog_angle_offsets_reg <= hae_pkg::REG_RESET;
      rd_data <= hae_pkg::REG_RESET;
    end else begin
      hall_mode_reg <= hall_mode_next;
      hall_angle_offsets_reg <= hall_angle_offsets_next;
      hall_interp_max_step_reg <= hall_interp_max_step_next;
      analog_enc_config_reg <= analog_enc_config_next;
      analog_index_threshold_reg <= analog_index_threshold_next;
      analog_angle_offset_reg <= analog_angle_offset_next;
      analog_periods_per_rev_reg <= analog_periods_per_rev_next;
      analog_angle_offsets_reg <= analog_angle_offsets_next;
      rd_data <= rd_data_next;
    end
  end

  // ----------------------------------------
  // Hall decoder
  // ----------------------------------------
  logic [2:0] new_sector;
  logic [15:0] base_angle, acc_sum;
  always_comb begin
    new_sector = hall_sector(hall_in);
    sector_next = sector_reg;
    interval_next = (interval_reg == hae_pkg::INTERVAL_MAX) ? interval_reg : interval_reg + 16'h0001;
    step_next = step_reg;
    fwd_next = fwd_reg;
    acc_sum = acc_reg + step_reg;
    acc_next = (acc_sum < acc_reg || acc_sum > hall_interp_max_step_reg)
      ? hall_interp_max_step_reg : acc_sum;

    // ----------------------------------------
    // Sector change
    // ----------------------------------------
    if (new_sector != 3'h7 && new_sector != sector_reg) begin
      sector_next = new_sector;
      fwd_next = (new_sector == ((sector_reg == 3'h5) ? 3'h0 : sector_reg + 3'h1));
      step_next = hae_pkg::SIXTY_DEG >> msb_index(interval_reg);
      interval_next = 16'h0000;
      acc_next = 16'h0000;
    end

    // ----------------------------------------
    // Angles and offsets
    // ----------------------------------------
    base_angle = 16'(sector_next * hae_pkg::SIXTY_DEG);
    hall_raw_next = base_angle + hall_angle_offsets_reg[31:16];
    hall_mech_next = base_angle + hall_angle_offsets_reg[15:0];
    hall_interp_next = fwd_next ? hall_raw_next + acc_next : hall_raw_next - acc_next;
    hall_sel_next = hall_mode_reg[hae_pkg::HALL_MODE_INTERP_BIT]
      ? hall_interp_next : hall_raw_next;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sector_reg <= 3'h0;
      interval_reg <= 16'h0000;
      step_reg <= 16'h0000;
      acc_reg <= 16'h0000;
      fwd_reg <= 1'b1;
      hall_raw_reg <= 16'h0000;
      hall_interp_reg <= 16'h0000;
      hall_mech_reg <= 16'h0000;
      hall_phi_e_sel <= 16'h0000;
      hall_phi_m_out <= 16'h0000;
    end else begin
      sector_reg <= sector_next;
      interval_reg <= interval_next;
      step_reg <= step_next;
      acc_reg <= acc_next;
      fwd_reg <= fwd_next;
      hall_raw_reg <= hall_raw_next;
      hall_interp_reg <= hall_interp_next;
      hall_mech_reg <= hall_mech_next;
      hall_phi_e_sel <= hall_sel_next;
      hall_phi_m_out <= hall_mech_next;
    end
  end

  // ----------------------------------------
  // Analog decoder
  // ----------------------------------------
  logic signed [16:0] diff_vw;
  logic signed [33:0] beta_prod;
  logic signed [17:0] xa, ya, xs, ys;
  logic dir_neg, wrap_fwd, wrap_bwd, index_event;
  always_comb begin
    cst_next = cst_reg;
    iter_next = iter_reg;
    x_next = x_reg;
    y_next = y_reg;
    z_next = z_reg;
    analog_raw_angle_next = analog_raw_angle_reg;
    diff_vw = 17'(aenc_in.ph1) - 17'(aenc_in.ph2);
    beta_prod = 34'(diff_vw) * 34'($signed({1'b0, hae_pkg::INV_SQRT3}));
    xa = 18'(aenc_in.ph0);
    ya = analog_enc_config_reg[hae_pkg::AENC_THREE_PHASE_BIT]
      ? beta_prod[hae_pkg::INV_SQRT3_SHIFT +: 18] : 18'(aenc_in.ph1);
    xs = x_reg >>> iter_reg;
    ys = y_reg >>> iter_reg;

    // ----------------------------------------
    // Arctangent iterations
    // ----------------------------------------
    case (cst_reg)
      hae_pkg::CORDIC_LOAD: begin
        x_next = xa[17] ? -xa : xa;
        y_next = xa[17] ? -ya : ya;
        z_next = xa[17] ? hae_pkg::HALF_TURN : 16'h0000;
        iter_next = 4'h0;
        cst_next = hae_pkg::CORDIC_ITER;
      end
      hae_pkg::CORDIC_ITER: begin
        if (!y_reg[17]) begin
          x_next = x_reg + ys;
          y_next = y_reg - xs;
          z_next = z_reg + hae_pkg::atan_lut(iter_reg);
        end else begin
          x_next = x_reg - ys;
          y_next = y_reg + xs;
          z_next = z_reg - hae_pkg::atan_lut(iter_reg);
        end
        iter_next = iter_reg + 4'h1;
        if (iter_reg == hae_pkg::CORDIC_LAST) begin
          cst_next = hae_pkg::CORDIC_DONE;
        end
      end
      hae_pkg::CORDIC_DONE: begin
        analog_raw_angle_next = z_reg;
        cst_next = hae_pkg::CORDIC_LOAD;
      end
      default: cst_next = hae_pkg::CORDIC_LOAD;
    endcase

    // ----------------------------------------
    // Offset and wrap detection
    // ----------------------------------------
    analog_comp_angle_next = analog_raw_angle_reg + analog_angle_offset_reg;
    comp_prev_next = analog_comp_angle_reg;
    dir_neg = analog_enc_config_reg[hae_pkg::AENC_DIR_NEG_BIT];
    wrap_fwd = (comp_prev_reg[15:14] == 2'h3) && (analog_comp_angle_reg[15:14] == 2'h0);
    wrap_bwd = (comp_prev_reg[15:14] == 2'h0) && (analog_comp_angle_reg[15:14] == 2'h3);
    index_level_next = aenc_in.index_level > analog_index_threshold_reg;
    index_event = index_level_next && !index_level_reg;

    // ----------------------------------------
    // Period count
    // ----------------------------------------
    analog_period_count_next = analog_period_count_reg;
    if (wrap_fwd != wrap_bwd) begin
      analog_period_count_next = (wrap_fwd != dir_neg)
        ? analog_period_count_reg + 32'h0000_0001
        : analog_period_count_reg - 32'h0000_0001;
    end

    // ----------------------------------------
    // Index capture and reload
    // ----------------------------------------
    analog_index_capture_next = analog_index_capture_reg;
    if (bus_req.wr && bus_req.addr == hae_pkg::ADDR_AENC_CAPTURE) begin
      analog_index_capture_next = bus_req.wdata;
    end
    if (index_event) begin
      if (analog_enc_config_reg[hae_pkg::AENC_RELOAD_BIT]) begin
        analog_period_count_next = analog_index_capture_reg;
      end else begin
        analog_index_capture_next = analog_period_count_next;
      end
    end

    // ----------------------------------------
    // Software count write wins
    // ----------------------------------------
    if (bus_req.wr && bus_req.addr == hae_pkg::ADDR_AENC_COUNT) begin
      analog_period_count_next = bus_req.wdata;
    end
    index_pulse_next = index_event;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cst_reg <= hae_pkg::CORDIC_LOAD;
      iter_reg <= 4'h0;
      x_reg <= 18'sh00000;
      y_reg <= 18'sh00000;
      z_reg <= 16'h0000;
      analog_raw_angle_reg <= 16'h0000;
      analog_comp_angle_reg <= 16'h0000;
      comp_prev_reg <= 16'h0000;
      analog_period_count_reg <= hae_pkg::REG_RESET;
      analog_index_capture_reg <= hae_pkg::REG_RESET;
      index_level_reg <= 1'b0;
      aenc_index_pulse <= 1'b0;
      aenc_phi_a_out <= 16'h0000;
    end else begin
      cst_reg <= cst_next;
      iter_reg <= iter_next;
      x_reg <= x_next;
      y_reg <= y_next;
      z_reg <= z_next;
      analog_raw_angle_reg <= analog_raw_angle_next;
      analog_comp_angle_reg <= analog_comp_angle_next;
      comp_prev_reg <= comp_prev_next;
      analog_period_count_reg <= analog_period_count_next;
      analog_index_capture_reg <= analog_index_capture_next;
      index_level_reg <= index_level_next;
      aenc_index_pulse <= index_pulse_next;
      aenc_phi_a_out <= analog_comp_angle_next;
    end
  end

endmodule

`default_nettype wire

// ==== testbench/hae_decoder_chk.sv ====
// Port checker for the Hall and analog encoder decoder
`timescale 1ns/10ps
`default_nettype none
module hae_decoder_chk (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire hae_pkg::hae_bus_req_t bus_req,
  input wire logic [31:0] rd_data,
  input wire logic [2:0] hall_in,
  input wire hae_pkg::hae_aenc_in_t aenc_in,
  input wire logic [15:0] hall_phi_e_sel,
  input wire logic [15:0] hall_phi_m_out,
  input wire logic [15:0] aenc_phi_a_out,
  input wire logic aenc_index_pulse
);
  // ----------
  // Register shadows, quiet counter
  // ----------
  logic [31:0] offs_reg, offs_next;
  logic [15:0] thr_reg, thr_next, mx_reg, mx_next, m_exp, e_exp, e_diff;
  logic intp_reg, intp_next, valid;
  logic [5:0] q_reg, q_next;
  logic [2:0] hall_p_reg;
  hae_pkg::hae_aenc_in_t ain_p_reg;
  function automatic logic [15:0] ang(input logic [2:0] c);
    case (c)
      3'h3: ang = 16'h2AAB;
      3'h2: ang = 16'h5556;
      3'h6: ang = 16'h8001;
      3'h4: ang = 16'hAAAC;
      3'h5: ang = 16'hD557;
      default: ang = 16'h0000;
    endcase
  endfunction
  always_comb begin
    offs_next = offs_reg;
    thr_next = thr_reg;
    mx_next = mx_reg;
    intp_next = intp_reg;
    if (bus_req.wr) begin
      case (bus_req.addr)
        hae_pkg::ADDR_HALL_OFFSETS: offs_next = bus_req.wdata;
        hae_pkg::ADDR_AENC_THRESHOLD: thr_next = bus_req.wdata[15:0];
        hae_pkg::ADDR_HALL_MAX_STEP: mx_next = bus_req.wdata[15:0];
        hae_pkg::ADDR_HALL_MODE: intp_next = bus_req.wdata[hae_pkg::HALL_MODE_INTERP_BIT];
        default: ;
      endcase
    end
    q_next = (q_reg == 6'h3F) ? q_reg : q_reg + 6'h01;
    if (bus_req.wr || hall_in != hall_p_reg || aenc_in != ain_p_reg) q_next = 6'h00;
    valid = hall_in != 3'h0 && hall_in != 3'h7;
    m_exp = ang(hall_in) + offs_reg[15:0];
    e_exp = ang(hall_in) + offs_reg[31:16];
    e_diff = hall_phi_e_sel - e_exp;
  end
  always_ff @(posedge sys_clk) begin
    hall_p_reg <= hall_in;
    ain_p_reg <= aenc_in;
    if (!rstn) begin
      offs_reg <= 32'h0;
      thr_reg <= 16'h0;
      mx_reg <= hae_pkg::MAX_STEP_RESET;
      intp_reg <= 1'b0;
      q_reg <= 6'h00;
    end else begin
      offs_reg <= offs_next;
      thr_reg <= thr_next;
      mx_reg <= mx_next;
      intp_reg <= intp_next;
      q_reg <= q_next;
    end
  end
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
    else $error("read data not idle");
  AST_HALL_MECH: assert property (q_reg >= 6'h04 && valid |-> hall_phi_m_out == m_exp)
    else $error("hall mech angle wrong");
  AST_HALL_RAW: assert property (q_reg >= 6'h04 && valid && !intp_reg |->
    hall_phi_e_sel == e_exp) else $error("hall raw elec angle wrong");
  AST_HALL_CLAMP: assert property (q_reg >= 6'h04 && valid && intp_reg |->
    e_diff <= mx_reg || (16'h0 - e_diff) <= mx_reg) else $error("interp step too big");
  AST_RD_MECH: assert property ($past(bus_req.rd) && q_reg >= 6'h06 && valid &&
    $past(bus_req.addr) == hae_pkg::ADDR_HALL_MECH |-> rd_data == {16'h0, m_exp})
    else $error("mech read wrong");
  AST_RD_THR: assert property ($past(bus_req.rd) &&
    $past(bus_req.addr) == hae_pkg::ADDR_AENC_THRESHOLD |-> rd_data == {16'h0, thr_reg})
    else $error("threshold read wrong");
  AST_AENC_HOLD: assert property (q_reg >= 6'd40 |-> $stable(aenc_phi_a_out))
    else $error("analog angle moves with steady inputs");
  AST_PULSE_ONE: assert property (aenc_index_pulse |=> !aenc_index_pulse)
    else $error("index pulse too long");
  AST_PULSE_CAUSE: assert property (aenc_index_pulse |->
    $past(aenc_in.index_level) > thr_reg || $past(aenc_in.index_level, 2) > thr_reg)
    else $error("index pulse without level");
  AST_PULSE_NEED: assert property ($rose(aenc_in.index_level > thr_reg) |->
    ##[1:3] aenc_index_pulse) else $error("index pulse missing");
endmodule
bind hae_decoder hae_decoder_chk hae_decoder_chk_inst (.sys_clk(sys_clk), .rstn(rstn),
  .bus_req(bus_req), .rd_data(rd_data), .hall_in(hall_in), .aenc_in(aenc_in),
  .hall_phi_e_sel(hall_phi_e_sel), .hall_phi_m_out(hall_phi_m_out),
  .aenc_phi_a_out(aenc_phi_a_out), .aenc_index_pulse(aenc_index_pulse));
`default_nettype wire

// ==== testbench/hae_sensor_model.sv ====
// Sensor model: Hall codes and analog encoder phases
`timescale 1ns/10ps
`default_nettype none
module hae_sensor_model (
  input wire logic sys_clk,
  input wire logic [2:0] sector,
  input wire logic hall_bad,
  input wire logic [15:0] theta,
  input wire logic three_ph,
  input wire logic [15:0] index_level,
  output logic [2:0] hall_in,
  output hae_pkg::hae_aenc_in_t aenc_in
);
  localparam logic [2:0] CODES [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  localparam real AMP = 12000.0;
  localparam real THIRD = 2.0943951;
  real t;
  logic flip = 1'b0;
  // Invalid codes glitch between all-low and all-high
  always @(posedge sys_clk) begin
    t = 6.2831853 * real'(theta) / 65536.0;
    flip <= ~flip;
    hall_in <= hall_bad ? {3{flip}} : CODES[sector];
    aenc_in.ph0 <= 16'($rtoi(AMP * $cos(t)));
    aenc_in.ph1 <= 16'($rtoi(AMP * (three_ph ? $cos(t - THIRD) : $sin(t))));
    aenc_in.ph2 <= three_ph ? 16'($rtoi(AMP * $cos(t + THIRD))) : 16'h0000;
    aenc_in.index_level <= index_level;
  end
endmodule
`default_nettype wire

// ==== testbench/hae_decoder_tb.sv ====
// Self-checking bench for the Hall and analog encoder decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module hae_decoder_tb;
  logic sys_clk, rstn, three_ph, hall_bad, pulse;
  logic [2:0] hall_in, sector;
  logic [15:0] theta, index_level, e_sel, m_out, a_out, moff, eoff, v16;
  logic [31:0] d, v, base, d_bus;
  hae_pkg::hae_bus_req_t bus_req;
  hae_pkg::hae_aenc_in_t aenc_in;
  integer seed = 32'ha52c99b8;
  int checked = 0;
  int miscompares = 0;
  int cycles = 0;
  int pulses = 0;
  logic [7:0] rw [10] = '{8'h33, 8'h37, 8'h38, 8'h3B, 8'h3C, 8'h40, 8'h41, 8'h42, 8'h3E, 8'h45};
  hae_decoder hae_decoder_inst (.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
    .rd_data(d_bus), .hall_in(hall_in), .aenc_in(aenc_in), .hall_phi_e_sel(e_sel),
    .hall_phi_m_out(m_out), .aenc_phi_a_out(a_out), .aenc_index_pulse(pulse));
  hae_sensor_model hae_sensor_model_inst (.sys_clk(sys_clk), .sector(sector),
    .hall_bad(hall_bad), .theta(theta), .three_ph(three_ph), .index_level(index_level),
    .hall_in(hall_in), .aenc_in(aenc_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] sang(input int s);
    return 16'(s * 16'h2AAB);
  endfunction
  function automatic logic near(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] x;
    x = a - b;
    return x < 16'h0020 || x > 16'hFFE0;
  endfunction
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    bus_req <= {a, w, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge sys_clk);
    bus_req <= {a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    @(negedge sys_clk);
    r = d_bus;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (pulse === 1'b1) pulses++;
    if (cycles == 10000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    rstn = 1'b0;
    bus_req = '0;
    sector = 3'h0;
    hall_bad = 1'b0;
    theta = 16'h2000;
    three_ph = 1'b0;
    index_level = 16'h0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    // ----------
    // Register reset values and read back
    // ----------
    foreach (rw[i]) begin
      rd(rw[i], d);
      `CHK("reset", (rw[i] == 8'h38) ? 32'h2AAA : 32'h0, d)
      v = $random(seed);
      if (rw[i] == 8'h40) v = 32'h1 << v[3:0];
      wr(rw[i], v);
      rd(rw[i], d);
      `CHK("rw", (rw[i] inside {8'h38, 8'h3C, 8'h3E, 8'h40}) ? v & 32'hFFFF : v, d)
    end
    wr(8'h50, 32'hFFFF_FFFF);
    rd(8'h50, d);
    `CHK("unmapped", 32'h0, d)
    // ----------
    // Hall sectors, invalid codes, interpolation
    // ----------
    moff = 16'($random(seed));
    eoff = 16'($random(seed));
    wr(8'h33, 32'h0);
    wr(8'h37, {eoff, moff});
    wr(8'h38, 32'h0100);
    wr(8'h3A, 32'hFFFF);
    for (int s = 1; s < 14; s++) begin
      hall_bad <= 1'b1;
      idle(5);
      hall_bad <= 1'b0;
      sector <= 3'(s % 6);
      idle(40);
      v16 = sang(s % 6) + moff;
      rd(8'h3A, d);
      `CHK("mech", {16'h0, v16}, d)
      v16 = sang(s % 6) + eoff;
      rd(8'h39, d);
      `CHK("raw elec", v16, d[15:0])
      if (s > 8) `CHK("interp", v16 + 16'h0100, d[31:16])
      `CHK("sel", (s > 8) ? v16 + 16'h0100 : v16, e_sel)
      if (s == 8) wr(8'h33, 32'h0100);
      idle(1);
    end
    // ----------
    // Analog angle in both modes
    // ----------
    v16 = 16'($random(seed));
    wr(8'h3E, {16'h0, v16});
    for (int k = 0; k < 12; k++) begin
      if (k % 6 == 0) wr(8'h3B, 32'(k / 6));
      three_ph <= 1'(k / 6);
      theta <= 16'($random(seed));
      idle(40);
      rd(8'h3D, d);
      `CHK("raw", 1'b1, near(d[15:0], theta))
      base = d + {16'h0, v16};
      rd(8'h3F, d);
      `CHK("comp", base & 32'hFFFF, d)
      `CHK("out", base[15:0], a_out)
      idle(1);
    end
    // ----------
    // Period count in both directions
    // ----------
    wr(8'h3E, 32'h0);
    for (int dir = 0; dir < 2; dir++) begin
      theta <= 16'h9000;
      three_ph <= 1'b0;
      wr(8'h3B, 32'(dir << 12));
      idle(40);
      base = $random(seed);
      wr(8'h41, base);
      for (int t = 5; t < 9; t++) begin
        theta <= 16'(t * 16'h2000 + 16'h1000);
        idle(40);
      end
      rd(8'h41, d);
      `CHK("count", (dir == 1) ? base - 32'h1 : base + 32'h1, d)
      idle(1);
    end
    // ----------
    // Index capture and reload
    // ----------
    wr(8'h3B, 32'h0);
    wr(8'h3C, 32'h4000);
    base = $random(seed);
    wr(8'h41, base);
    d = 32'(pulses);
    index_level <= 16'h4000;
    idle(10);
    `CHK("no pulse", d, 32'(pulses))
    index_level <= 16'h4001;
    idle(10);
    `CHK("pulse", d + 32'h1, 32'(pulses))
    rd(8'h42, d);
    `CHK("capture", base, d)
    idle(1);
    index_level <= 16'h0;
    wr(8'h3B, 32'h0100);
    v = $random(seed);
    wr(8'h42, v);
    wr(8'h41, base);
    index_level <= 16'hFFFF;
    idle(10);
    rd(8'h41, d);
    `CHK("reload", v, d)
    rd(8'h42, d);
    `CHK("kept", v, d)
    stop_test();
  end
endmodule
`default_nettype wire
